/* File: core/tacc_pkg.sv */
// Shared constants for the thermal alert configuration control block.
package tacc_pkg;
    // Register pointers seen by the serial front end.
    localparam logic [7:0] ADDR_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_UPPER = 8'h02;
    localparam logic [7:0] ADDR_LOWER = 8'h03;
    localparam logic [7:0] ADDR_CRIT = 8'h04;
    localparam logic [7:0] ADDR_TEMP = 8'h05;

    // Configuration register bit positions.
    localparam int CFG_CRIT_LOCK = 7;
    localparam int CFG_WIN_LOCK = 6;
    localparam int CFG_CLEAR = 5;
    localparam int CFG_STATUS = 4;
    localparam int CFG_OUT_EN = 3;
    localparam int CFG_CRIT_ONLY = 2;
    localparam int CFG_POLARITY = 1;
    localparam int CFG_MODE = 0;
    localparam int CFG_SHUTDOWN = 8;
    localparam int CFG_HYS_LO = 9;
    localparam int CFG_HYS_HI = 10;

    // Temperature register trip status positions.
    localparam int TEMP_BELOW = 13;
    localparam int TEMP_ABOVE = 14;
    localparam int TEMP_CRIT = 15;

    // Trip thresholds keep bits 12:2; the rest read as zero.
    localparam int TRIP_MSB = 12;
    localparam int TRIP_LSB = 2;
    localparam int TEMP_W = 13;

    // Hysteresis in temperature-word units, where bit 0 weighs 0.0625 C.
    localparam logic [TEMP_W-1:0] HYS_NONE = 13'h0000;
    localparam logic [TEMP_W-1:0] HYS_1P5C = 13'h0018;
    localparam logic [TEMP_W-1:0] HYS_3C = 13'h0030;
    localparam logic [TEMP_W-1:0] HYS_6C = 13'h0060;

    localparam logic [15:0] REG_ZERO = 16'h0000;
    localparam int TRIP_N = 3;
    localparam int TRIP_BELOW_IDX = 0;
    localparam int TRIP_ABOVE_IDX = 1;
    localparam int TRIP_CRIT_IDX = 2;
endpackage

/* File: core/tacc_trip_if.sv */
// Carrier between the control block and one trip comparator.
`timescale 1ns/1ps
interface tacc_trip_if;
    import tacc_pkg::*;
    logic signed [TEMP_W-1:0] temp;
    logic signed [TEMP_W-1:0] threshold;
    logic [TEMP_W-1:0] hysteresis;
    logic sample;
    logic low_side;
    logic status;

    modport ctrl (output temp, output threshold, output hysteresis, output sample,
                  output low_side, input status);
    modport trip (input temp, input threshold, input hysteresis, input sample,
                  input low_side, output status);
endinterface

/* File: core/tacc_trip.sv */
// One trip status bit with hysteresis around its threshold.
`timescale 1ns/1ps
module tacc_trip
    import tacc_pkg::*;
(
    input wire logic clk_i,        // System clock.
    input wire logic rst_b_i,      // Power-on reset, active low.
    tacc_trip_if.trip trip_if      // Comparator inputs and status.
);
    logic status_q;
    logic signed [TEMP_W:0] temp_x;
    logic signed [TEMP_W:0] thr_x;
    logic signed [TEMP_W:0] thr_hys;

    // One extra bit keeps threshold minus hysteresis from wrapping.
    assign temp_x = {trip_if.temp[TEMP_W-1], trip_if.temp};
    assign thr_x = {trip_if.threshold[TEMP_W-1], trip_if.threshold};
    assign thr_hys = thr_x - $signed({1'b0, trip_if.hysteresis});
    assign trip_if.status = status_q;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            status_q <= 1'b0;
        end else if (trip_if.sample) begin
            if (trip_if.low_side) begin
                if (temp_x >= thr_x) begin
                    status_q <= 1'b0;
                end else if (temp_x <= thr_hys) begin
                    status_q <= 1'b1;
                end
            end else begin
                if (temp_x > thr_x) begin
                    status_q <= 1'b1;
                end else if (temp_x <= thr_hys) begin
                    status_q <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: core/tacc_config.sv */
// Configuration register, trip registers and alert pin control.
`timescale 1ns/1ps
module tacc_config
    import tacc_pkg::*;
(
    input wire logic clk_i,                    // System clock, 200 MHz.
    input wire logic rst_b_i,                  // Power-on reset, active low.
    input wire logic reg_wr_i,                 // Register write strobe.
    input wire logic reg_rd_i,                 // Register read strobe.
    input wire logic [7:0] reg_addr_i,         // Register pointer.
    input wire logic [15:0] reg_wdata_i,       // Write data.
    output logic [15:0] reg_rdata_o,           // Read data, valid after a read.
    input wire logic temp_valid_i,             // New conversion result strobe.
    input wire logic [TEMP_W-1:0] temp_i,      // Conversion result, two's complement.
    output logic shutdown_o,                   // Sensor shutdown request.
    output logic alert_o,                      // Alert pin output level.
    output logic alert_oe_o                    // Alert pin drive enable.
);
    logic crit_lock_q;
    logic win_lock_q;
    logic out_en_q;
    logic crit_only_q;
    logic polarity_q;
    logic mode_q;
    logic shutdown_q;
    logic [1:0] hys_sel_q;
    logic [TRIP_MSB:TRIP_LSB] upper_q;
    logic [TRIP_MSB:TRIP_LSB] lower_q;
    logic [TRIP_MSB:TRIP_LSB] crit_q;
    logic [TEMP_W-1:0] temp_q;
    logic latch_q;
    logic cond_prev_q;
    logic asserted_q;
    logic [15:0] rdata_q;
    logic alert_q;
    logic alert_oe_q;

    logic any_lock;
    logic wr_cfg;
    logic clear_req;
    logic sample;
    logic cond;
    logic asserted_d;
    logic [TEMP_W-1:0] hys_amt;
    logic [TRIP_N-1:0] trip_status;
    logic [15:0] cfg_read;
    logic [15:0] temp_read;
    logic [15:0] upper_read;
    logic [15:0] lower_read;
    logic [15:0] crit_read;
    logic wr_upper;
    logic wr_lower;
    logic wr_crit;
    logic wr_ctrl;
    logic cond_rise;
    logic alert_oe_d;

    assign any_lock = crit_lock_q | win_lock_q;
    assign wr_cfg = reg_wr_i && (reg_addr_i == ADDR_CONFIG);
    assign clear_req = wr_cfg && reg_wdata_i[CFG_CLEAR];
    assign sample = temp_valid_i && !shutdown_q;
    assign wr_ctrl = wr_cfg && !any_lock;
    assign wr_upper = reg_wr_i && (reg_addr_i == ADDR_UPPER) && !win_lock_q;
    assign wr_lower = reg_wr_i && (reg_addr_i == ADDR_LOWER) && !win_lock_q;
    assign wr_crit = reg_wr_i && (reg_addr_i == ADDR_CRIT) && !crit_lock_q;

    always_comb begin
        case (hys_sel_q)
            2'b00: hys_amt = HYS_NONE;
            2'b01: hys_amt = HYS_1P5C;
            2'b10: hys_amt = HYS_3C;
            2'b11: hys_amt = HYS_6C;
            default: hys_amt = HYS_NONE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            crit_lock_q <= 1'b0;
        end else if (wr_cfg) begin
            crit_lock_q <= crit_lock_q | reg_wdata_i[CFG_CRIT_LOCK];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            win_lock_q <= 1'b0;
        end else if (wr_cfg) begin
            win_lock_q <= win_lock_q | reg_wdata_i[CFG_WIN_LOCK];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            out_en_q <= 1'b0;
            crit_only_q <= 1'b0;
            polarity_q <= 1'b0;
            mode_q <= 1'b0;
            hys_sel_q <= 2'b00;
        end else if (wr_ctrl) begin
            out_en_q <= reg_wdata_i[CFG_OUT_EN];
            crit_only_q <= reg_wdata_i[CFG_CRIT_ONLY];
            polarity_q <= reg_wdata_i[CFG_POLARITY];
            mode_q <= reg_wdata_i[CFG_MODE];
            hys_sel_q <= reg_wdata_i[CFG_HYS_HI:CFG_HYS_LO];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            shutdown_q <= 1'b0;
        end else if (wr_cfg) begin
            if (!reg_wdata_i[CFG_SHUTDOWN] || !any_lock) begin
                shutdown_q <= reg_wdata_i[CFG_SHUTDOWN];
            end
        end
    end

    // Trip threshold registers; the temperature register is read-only.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            upper_q <= '0;
        end else if (wr_upper) begin
            upper_q <= reg_wdata_i[TRIP_MSB:TRIP_LSB];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            lower_q <= '0;
        end else if (wr_lower) begin
            lower_q <= reg_wdata_i[TRIP_MSB:TRIP_LSB];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            crit_q <= '0;
        end else if (wr_crit) begin
            crit_q <= reg_wdata_i[TRIP_MSB:TRIP_LSB];
        end
    end

    // Holding the last sample while shut down keeps the temperature reading stable.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            temp_q <= '0;
        end else if (sample) begin
            temp_q <= temp_i;
        end
    end

    // Each comparator looks at the same sample it will judge.
    genvar gi;
    generate
        for (gi = 0; gi < TRIP_N; gi++) begin : g_trip
            tacc_trip_if tif ();
            logic [TRIP_MSB:TRIP_LSB] thr;
            if (gi == TRIP_BELOW_IDX) begin : g_lo
                assign thr = lower_q;
            end else if (gi == TRIP_ABOVE_IDX) begin : g_up
                assign thr = upper_q;
            end else begin : g_cr
                assign thr = crit_q;
            end
            assign tif.temp = $signed(temp_i);
            assign tif.threshold = $signed({thr, 2'b00});
            assign tif.hysteresis = hys_amt;
            assign tif.sample = sample;
            assign tif.low_side = (gi == TRIP_BELOW_IDX);
            assign trip_status[gi] = tif.status;
            tacc_trip u_trip (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .trip_if(tif)
            );
        end
    endgenerate

    assign cond = trip_status[TRIP_CRIT_IDX] |
                  (!crit_only_q & (trip_status[TRIP_ABOVE_IDX] | trip_status[TRIP_BELOW_IDX]));

    // Only a fresh condition latches, so a lasting one cannot raise a cleared alert again.
    assign cond_rise = cond && !cond_prev_q;

    // A new rising condition wins over a clear in the same cycle.
    // latched interrupt
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            latch_q <= 1'b0;
            cond_prev_q <= 1'b0;
        end else begin
            cond_prev_q <= cond;
            if (!mode_q) begin
                latch_q <= 1'b0;
            end else if (cond_rise) begin
                latch_q <= 1'b1;
            end else if (clear_req) begin
                latch_q <= 1'b0;
            end
        end
    end

    assign asserted_d = out_en_q & (mode_q ? latch_q : cond);

    // polarity
    // Open drain: active low drives 0 when asserted, active high drives 0 when idle.
    assign alert_oe_d = polarity_q ? !asserted_d : asserted_d;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            asserted_q <= 1'b0;
            alert_q <= 1'b0;
            alert_oe_q <= 1'b0;
        end else begin
            asserted_q <= asserted_d;
            alert_q <= 1'b0;
            alert_oe_q <= alert_oe_d;
        end
    end

    always_comb begin
        cfg_read = REG_ZERO;
        cfg_read[CFG_CRIT_LOCK] = crit_lock_q;
        cfg_read[CFG_WIN_LOCK] = win_lock_q;
        cfg_read[CFG_STATUS] = asserted_q;
        cfg_read[CFG_OUT_EN] = out_en_q;
        cfg_read[CFG_CRIT_ONLY] = crit_only_q;
        cfg_read[CFG_POLARITY] = polarity_q;
        cfg_read[CFG_MODE] = mode_q;
        cfg_read[CFG_SHUTDOWN] = shutdown_q;
        cfg_read[CFG_HYS_HI:CFG_HYS_LO] = hys_sel_q;
    end

    always_comb begin
        temp_read = REG_ZERO;
        temp_read[TEMP_W-1:1] = temp_q[TEMP_W-1:1];
        temp_read[TEMP_BELOW] = trip_status[TRIP_BELOW_IDX];
        temp_read[TEMP_ABOVE] = trip_status[TRIP_ABOVE_IDX];
        temp_read[TEMP_CRIT] = trip_status[TRIP_CRIT_IDX];
    end

    // Trip registers read back with their unused bits forced to zero.
    always_comb begin
        upper_read = REG_ZERO;
        lower_read = REG_ZERO;
        crit_read = REG_ZERO;
        upper_read[TRIP_MSB:TRIP_LSB] = upper_q;
        lower_read[TRIP_MSB:TRIP_LSB] = lower_q;
        crit_read[TRIP_MSB:TRIP_LSB] = crit_q;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_q <= REG_ZERO;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_CONFIG: rdata_q <= cfg_read;
                ADDR_UPPER: rdata_q <= upper_read;
                ADDR_LOWER: rdata_q <= lower_read;
                ADDR_CRIT: rdata_q <= crit_read;
                ADDR_TEMP: rdata_q <= temp_read;
                default: rdata_q <= REG_ZERO;
            endcase
        end
    end

    assign reg_rdata_o = rdata_q;
    assign shutdown_o = shutdown_q;
    assign alert_o = alert_q;
    assign alert_oe_o = alert_oe_q;
endmodule

/* File: dv/tacc_config_chk.sv */
// Port-level assertions for the alert configuration block.
`timescale 1ns/1ps
module tacc_config_chk
    import tacc_pkg::*;
(
    input wire logic clk_i,               // System clock.
    input wire logic rst_b_i,             // Reset, active low.
    input wire logic reg_wr_i,            // Write strobe.
    input wire logic reg_rd_i,            // Read strobe.
    input wire logic [7:0] reg_addr_i,    // Register pointer.
    input wire logic [15:0] reg_wdata_i,  // Write data.
    input wire logic [15:0] reg_rdata_o,  // Read data.
    input wire logic temp_valid_i,        // Sample strobe.
    input wire logic [TEMP_W-1:0] temp_i, // Sample value.
    input wire logic shutdown_o,          // Shutdown request.
    input wire logic alert_o,             // Pin level when driven.
    input wire logic alert_oe_o           // Pin drive enable.
);
    logic [1:0] lk_q;
    logic en_q;
    logic pol_q;
    logic mode_q;
    logic [2:0] en_h_q;
    logic [2:0] pol_h_q;
    wire cfg_wr = reg_wr_i && reg_addr_i == ADDR_CONFIG;
    wire cfg_rd = reg_rd_i && reg_addr_i == ADDR_CONFIG;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // The locks are judged before the write lands, so a locking write still sets the low bits.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            lk_q <= 2'h0;
            en_q <= 1'b0;
            pol_q <= 1'b0;
            mode_q <= 1'b0;
        end else if (cfg_wr) begin
            lk_q <= lk_q | reg_wdata_i[7:6];
            if (lk_q == 2'h0) begin
                en_q <= reg_wdata_i[CFG_OUT_EN];
                pol_q <= reg_wdata_i[CFG_POLARITY];
                mode_q <= reg_wdata_i[CFG_MODE];
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            en_h_q <= 3'h0;
            pol_h_q <= 3'h0;
        end else begin
            en_h_q <= {en_h_q[1:0], en_q};
            pol_h_q <= {pol_h_q[1:0], pol_q};
        end
    end
    sequence s_clear;
        cfg_wr && reg_wdata_i[CFG_CLEAR] && mode_q && !temp_valid_i && !$past(temp_valid_i)
            && !$past(temp_valid_i, 2) && (lk_q != 2'h0 || reg_wdata_i[1:0] == {pol_q, 1'b1});
    endsequence
    sequence s_quiet;
        (!temp_valid_i && !reg_wr_i)[*2];
    endsequence
    chk_pin_low: assert property (!alert_o)
        else $error("alert pin driven high");
    chk_clear_read: assert property (cfg_rd |=> !reg_rdata_o[CFG_CLEAR])
        else $error("clear bit read as one");
    chk_lock_read: assert property (cfg_rd |=> reg_rdata_o[7:6] == $past(lk_q))
        else $error("lock bits read wrong");
    chk_shutdown_set: assert property (cfg_wr && lk_q == 2'h0 && reg_wdata_i[8] ##1 !reg_wr_i |=> shutdown_o)
        else $error("shutdown not set");
    chk_shutdown_clear: assert property (cfg_wr && !reg_wdata_i[8] ##1 !reg_wr_i |=> !shutdown_o)
        else $error("shutdown not cleared");
    chk_shutdown_refuse: assert property (cfg_wr && lk_q != 2'h0 && !shutdown_o |=> !shutdown_o [*2])
        else $error("shutdown set while locked");
    chk_output_gate: assert property (!en_q && en_h_q == 3'h0 && pol_h_q == {3{pol_q}} |-> alert_oe_o == pol_q)
        else $error("alert asserted while disabled");
    chk_clear_intr: assert property (s_clear ##1 s_quiet |-> ##1 alert_oe_o == pol_q)
        else $error("alert not cleared");
endmodule
bind tacc_config tacc_config_chk chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .temp_valid_i(temp_valid_i), .temp_i(temp_i),
    .shutdown_o(shutdown_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o));

/* File: dv/tacc_host.sv */
// Host model: register accesses, samples and the pulled-up alert wire.
`timescale 1ns/1ps
module tacc_host
    import tacc_pkg::*;
(
    input wire logic clk_i,              // System clock.
    input wire logic [15:0] rdata_i,     // Read data.
    input wire logic alert_i,            // Pin level when driven.
    input wire logic alert_oe_i,         // Pin drive enable.
    output logic wr_o,                   // Write strobe.
    output logic rd_o,                   // Read strobe.
    output logic [7:0] addr_o,           // Register pointer.
    output logic [15:0] wdata_o,         // Write data.
    output logic tv_o,                   // Sample strobe.
    output logic [TEMP_W-1:0] temp_o,    // Sample value.
    output logic pin_o                   // Resolved wire level.
);
    // The wire has a pull-up, so a released pin reads high.
    assign pin_o = alert_oe_i ? alert_i : 1'b1;
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        tv_o = 1'b0;
        addr_o = 8'h00;
        temp_o = 13'h0000;
    end
    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask
    // Released data is inverted so that a stale value is never mistaken for a live one.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        settle();
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        settle();
        wr_o = 1'b0;
        wdata_o = ~d;
        settle();
        settle();
        settle();
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        settle();
        addr_o = a;
        rd_o = 1'b1;
        settle();
        rd_o = 1'b0;
        settle();
        d = rdata_i;
    endtask
    task automatic sample(input logic [TEMP_W-1:0] t);
        settle();
        temp_o = t;
        tv_o = 1'b1;
        settle();
        tv_o = 1'b0;
        temp_o = ~t;
        settle();
        settle();
        settle();
    endtask
endmodule

/* File: dv/thermal_alert_config_control_test.sv */
// Self-checking bench for the alert configuration block.
`timescale 1ns/1ps
module thermal_alert_config_control_test;
    import tacc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic reg_wr_i, reg_rd_i, temp_valid_i, shutdown_o, alert_o, alert_oe_o, pin;
    logic [7:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o;
    logic [TEMP_W-1:0] temp_i;
    int n_errors = 0;
    int checks = 0;
    always #2.5 clk_i = ~clk_i;
    tacc_config DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .temp_valid_i(temp_valid_i), .temp_i(temp_i), .shutdown_o(shutdown_o),
        .alert_o(alert_o), .alert_oe_o(alert_oe_o));
    tacc_host host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .alert_i(alert_o),
        .alert_oe_i(alert_oe_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .addr_o(reg_addr_i),
        .wdata_o(reg_wdata_i), .tv_o(temp_valid_i), .temp_o(temp_i), .pin_o(pin));
    task automatic end_sim();
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(a, d);
        cmp(what, exp, d);
    endtask
    task automatic trip(input logic [TEMP_W-1:0] t, input logic [2:0] exp);
        logic [15:0] d;
        host.sample(t);
        host.rd(ADDR_TEMP, d);
        cmp("trip bits", {13'h0000, exp}, {13'h0000, d[15:13]});
    endtask
    task automatic t_reset();
        rchk("config", ADDR_CONFIG, REG_ZERO);
        rchk("unmapped", 8'h07, REG_ZERO);
        cmp("pin", 16'h0001, {15'h0000, pin});
        host.wr(ADDR_CRIT, 16'hE641);
        rchk("critical", ADDR_CRIT, 16'h0640);
        host.wr(ADDR_UPPER, 16'h0500);
        host.wr(ADDR_LOWER, 16'h0100);
        rchk("upper", ADDR_UPPER, 16'h0500);
    endtask
    task automatic t_comparator();
        host.wr(ADDR_CONFIG, 16'h0008);
        host.sample(13'h0650);
        cmp("pin", REG_ZERO, {15'h0000, pin});
        rchk("temperature", ADDR_TEMP, 16'hC650);
        rchk("config", ADDR_CONFIG, 16'h0018);
        host.wr(ADDR_CONFIG, 16'h0028);
        cmp("pin", REG_ZERO, {15'h0000, pin});
        host.sample(13'h0300);
        cmp("pin", 16'h0001, {15'h0000, pin});
        rchk("config", ADDR_CONFIG, 16'h0008);
        host.wr(ADDR_CONFIG, 16'h0018);
        rchk("config", ADDR_CONFIG, 16'h0008);
    endtask
    task automatic t_hysteresis();
        logic [TEMP_W-1:0] hys [4] = '{HYS_NONE, HYS_1P5C, HYS_3C, HYS_6C};
        for (int k = 0; k < 4; k++) begin
            host.wr(ADDR_CONFIG, {5'h00, 2'(k), 9'h000});
            trip(13'h0650, 3'h6);
            trip(13'h0642 - hys[k], 3'h6);
            trip(13'h0640 - hys[k], 3'h2);
        end
        trip(13'h00A2, 3'h0);
        trip(13'h00A0, 3'h1);
        trip(13'h00FE, 3'h1);
        trip(13'h0100, 3'h0);
        trip(13'h0501, 3'h2);
        trip(13'h04A1, 3'h2);
        trip(13'h04A0, 3'h0);
    endtask
    task automatic t_interrupt();
        host.wr(ADDR_CONFIG, 16'h0009);
        host.sample(13'h0650);
        cmp("pin", REG_ZERO, {15'h0000, pin});
        host.sample(13'h0300);
        cmp("pin", REG_ZERO, {15'h0000, pin});
        rchk("config", ADDR_CONFIG, 16'h0019);
        host.wr(ADDR_CONFIG, 16'h0019);
        cmp("pin", REG_ZERO, {15'h0000, pin});
        host.wr(ADDR_CONFIG, 16'h0029);
        cmp("pin", 16'h0001, {15'h0000, pin});
        rchk("config", ADDR_CONFIG, 16'h0009);
        host.wr(ADDR_CONFIG, 16'h000E);
        host.sample(13'h0550);
        cmp("pin", REG_ZERO, {15'h0000, pin});
        host.sample(13'h0650);
        cmp("pin", 16'h0001, {15'h0000, pin});
    endtask
    task automatic t_lock();
        host.wr(ADDR_CONFIG, 16'h0180);
        cmp("shutdown", 16'h0001, {15'h0000, shutdown_o});
        cmp("pin", 16'h0001, {15'h0000, pin});
        rchk("config", ADDR_CONFIG, 16'h0180);
        host.wr(ADDR_CONFIG, 16'h070F);
        rchk("config", ADDR_CONFIG, 16'h0180);
        host.wr(ADDR_CRIT, 16'h0100);
        rchk("critical", ADDR_CRIT, 16'h0640);
        host.wr(ADDR_CONFIG, 16'h0040);
        rchk("config", ADDR_CONFIG, 16'h00C0);
        host.wr(ADDR_CONFIG, 16'h0140);
        cmp("shutdown", REG_ZERO, {15'h0000, shutdown_o});
        host.wr(ADDR_UPPER, 16'h0200);
        rchk("upper", ADDR_UPPER, 16'h0500);
        @(posedge clk_i);
        #1;
        rst_b_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        rchk("config", ADDR_CONFIG, REG_ZERO);
        host.wr(ADDR_CRIT, 16'h0100);
        rchk("critical", ADDR_CRIT, 16'h0100);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        t_reset();
        t_comparator();
        t_hysteresis();
        t_interrupt();
        t_lock();
        end_sim();
    end
    // The tests need well under a thousand cycles; this span leaves a wide margin.
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule
